// [hw/prox_pkg.sv]
/*
 Constants, field layouts, register offsets, state encodings and carrier
 types for the proximity control register block and its sequencer.
 Assumes a single 125 MHz clock and a two-wire serial host outside.
*/
// Function
// (RULE1) host sets top bit on command bytes
// (RULE2) command bits 6:5 select transaction type
// (RULE3) repeated type keeps the same address
// (RULE4) auto-increment type advances address per byte
// (RULE5) bits 4:0 give address or function code
// (RULE6) code 00101 clears interrupt, self clearing
// (RULE7) enable bit 5 masks proximity interrupts
// (RULE8) enable bit 3 switches wait timer
// (RULE9) enable bits 2:1 switch proximity function
// (RULE10) enable bit 0 gates oscillator and timers
// (RULE11) hold proximity 2.72 ms after power-on
// (RULE12) host programs wait before proximity enable
// (RULE13) host writes zero to unused enable bits
// (RULE14) integration time in 2.72 ms steps
// (RULE15) host should use single-cycle integration value
// (RULE16) wait step 2.72 ms, twelve times if long
// (RULE17) wait steps equal 256 minus setting
// (RULE18) thresholds are 16-bit from byte pairs
// (RULE19) out-of-range result signals interrupt event
// (RULE20) read without command uses stored address
// (RULE21) sequencer: delay, start, accumulate, convert, wait
// (RULE22) persistence zero fires every cycle, else consecutive
// (RULE23) status flag shows pending interrupt
// (RULE24) interrupt pin driven while pending and unmasked
// (RULE25) first top-bit byte is command, rest data
package prox_pkg;

   localparam int CLK_PERIOD_NS = 8;
   localparam int STEP_TIME_NS = 2720000;
   localparam int STEP_CYCLES = STEP_TIME_NS / CLK_PERIOD_NS;
   localparam logic [11:0] LONG_WAIT_FACTOR = 12'h00C;

   localparam logic [6:0] SLAVE_ADDR = 7'h39;

   localparam logic [4:0] ADDR_ENABLE = 5'h00;
   localparam logic [4:0] ADDR_ITIME = 5'h02;
   localparam logic [4:0] ADDR_WAIT = 5'h03;
   localparam logic [4:0] ADDR_LO_L = 5'h08;
   localparam logic [4:0] ADDR_LO_H = 5'h09;
   localparam logic [4:0] ADDR_HI_L = 5'h0A;
   localparam logic [4:0] ADDR_HI_H = 5'h0B;
   localparam logic [4:0] ADDR_PERS = 5'h0C;
   localparam logic [4:0] ADDR_CONFIG = 5'h0D;
   localparam logic [4:0] ADDR_STATUS = 5'h13;
   localparam logic [4:0] ADDR_DATA_L = 5'h18;
   localparam logic [4:0] ADDR_DATA_H = 5'h19;

   localparam int EN_OSC_BIT = 0;
   localparam int EN_PROX_LSB = 1;
   localparam int EN_WAIT_BIT = 3;
   localparam int EN_MASK_BIT = 5;
   localparam int CMD_SEL_BIT = 7;
   localparam int CFG_LONG_BIT = 1;
   localparam int STAT_PEND_BIT = 5;
   localparam int PERS_LSB = 4;

   localparam logic [1:0] PROX_ON = 2'h3;
   localparam logic [1:0] CMD_REPEAT = 2'h0;
   localparam logic [1:0] CMD_AUTO = 2'h1;
   localparam logic [1:0] CMD_SPECIAL = 2'h3;
   localparam logic [4:0] SF_NOP = 5'h00;
   localparam logic [4:0] SF_CLEAR = 5'h05;

   localparam logic [7:0] ENABLE_RST = 8'h00;
   localparam logic [7:0] ITIME_RST = 8'hFF;
   localparam logic [7:0] WAIT_RST = 8'hFF;
   localparam logic [15:0] THR_RST = 16'h0000;
   localparam logic [7:0] PERS_RST = 8'h00;
   localparam logic [7:0] CONFIG_RST = 8'h00;
   localparam logic [6:0] CMD_RST = 7'h00;

   typedef struct packed {
      logic [1:0] kind;
      logic [4:0] addr;
   } cmd_s;

   typedef struct packed {
      logic [7:0] enable;
      logic [7:0] itime;
      logic [7:0] wait_steps;
      logic [7:0] pers;
      logic [7:0] config_b;
      logic [15:0] lo_thr;
      logic [15:0] hi_thr;
      cmd_s cmd;
   } regs_s;

   typedef enum logic [6:0] {
      B_IDLE = 7'h01,
      B_ADDR = 7'h02,
      B_ACK_ADDR = 7'h04,
      B_RX = 7'h08,
      B_ACK_RX = 7'h10,
      B_TX = 7'h20,
      B_ACK_TX = 7'h40
   } bus_state_e;

   typedef enum logic [7:0] {
      S_SLEEP = 8'h01,
      S_START_DLY = 8'h02,
      S_START = 8'h04,
      S_ACCUM = 8'h08,
      S_CONVERT = 8'h10,
      S_WAIT_CHECK = 8'h20,
      S_WAIT = 8'h40,
      S_WAIT_DLY = 8'h80
   } seq_state_e;

endpackage

// [hw/prox_control.sv]
/*
 Proximity control block: two-wire serial slave, register bank, timing
 sequencer and threshold interrupt filter.
 Assumes scl/sda arrive asynchronously and an external pull-up resolves
 sda and the interrupt line; the converter result is on this clock.
*/
`timescale 1ns/100ps
module prox_control #(
   parameter int STEP_CYCLES = prox_pkg::STEP_CYCLES
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_o,
   output logic sda_oe_b,
   output logic int_o,
   output logic int_oe_b,
   output logic conv_start,
   input wire logic [15:0] prox_adc_value
);

   ////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic [8:0] steps_of(input logic [7:0] v);
      // (RULE17) two's complement count
      return 9'h100 - {1'b0, v};
   endfunction

   function automatic logic [7:0] read_byte(input prox_pkg::regs_s r,
                                            input logic [4:0] a,
                                            input logic pend,
                                            input logic [15:0] res,
                                            input logic [7:0] shadow);
      logic [7:0] d;
      d = 8'h00;
      case (a)
         prox_pkg::ADDR_ENABLE: d = r.enable;
         prox_pkg::ADDR_ITIME: d = r.itime;
         prox_pkg::ADDR_WAIT: d = r.wait_steps;
         prox_pkg::ADDR_LO_L: d = r.lo_thr[7:0];
         prox_pkg::ADDR_LO_H: d = r.lo_thr[15:8];
         prox_pkg::ADDR_HI_L: d = r.hi_thr[7:0];
         prox_pkg::ADDR_HI_H: d = r.hi_thr[15:8];
         prox_pkg::ADDR_PERS: d = r.pers;
         prox_pkg::ADDR_CONFIG: d = r.config_b;
         // (RULE23) status pending flag
         prox_pkg::ADDR_STATUS: d[prox_pkg::STAT_PEND_BIT] = pend;
         prox_pkg::ADDR_DATA_L: d = res[7:0];
         prox_pkg::ADDR_DATA_H: d = shadow;
         default: d = 8'h00;
      endcase
      return d;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic scl_meta, scl_sync, scl_prev;
   logic sda_meta, sda_sync, sda_prev;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         scl_meta <= 1'b1;
         scl_sync <= 1'b1;
         scl_prev <= 1'b1;
         sda_meta <= 1'b1;
         sda_sync <= 1'b1;
         sda_prev <= 1'b1;
      end else begin
         scl_meta <= scl_in;
         scl_sync <= scl_meta;
         scl_prev <= scl_sync;
         sda_meta <= sda_in;
         sda_sync <= sda_meta;
         sda_prev <= sda_sync;
      end
   end

   logic scl_rise, scl_fall, bus_start, bus_stop;
   assign scl_rise = scl_sync & ~scl_prev;
   assign scl_fall = ~scl_sync & scl_prev;
   assign bus_start = scl_sync & scl_prev & sda_prev & ~sda_sync;
   assign bus_stop = scl_sync & scl_prev & ~sda_prev & sda_sync;

   ////////////////////////////////////////////////////////////////////////
   // serial slave and register bank

   prox_pkg::bus_state_e bus_reg, bus_next;
   prox_pkg::regs_s regs_reg, regs_next;
   logic [3:0] cnt_reg, cnt_next;
   logic [7:0] shift_reg, shift_next;
   logic [7:0] tx_reg, tx_next;
   logic [7:0] shadow_reg, shadow_next;
   logic rw_reg, rw_next;
   logic first_reg, first_next;
   logic nack_reg, nack_next;
   logic oe_b_reg, oe_b_next;
   logic clear_req;
   logic pend_reg, pend_next;
   logic [15:0] result_reg, result_next;

   always_comb begin
      logic do_load;
      logic do_write;
      do_load = 1'b0;
      do_write = 1'b0;
      bus_next = bus_reg;
      regs_next = regs_reg;
      cnt_next = cnt_reg;
      shift_next = shift_reg;
      tx_next = tx_reg;
      shadow_next = shadow_reg;
      rw_next = rw_reg;
      first_next = first_reg;
      nack_next = nack_reg;
      oe_b_next = oe_b_reg;
      clear_req = 1'b0;
      if (bus_start) begin
         bus_next = prox_pkg::B_ADDR;
         cnt_next = 4'h0;
         first_next = 1'b1;
         oe_b_next = 1'b1;
      end else if (bus_stop) begin
         bus_next = prox_pkg::B_IDLE;
         oe_b_next = 1'b1;
      end else begin
         case (bus_reg)
            prox_pkg::B_IDLE: begin
               oe_b_next = 1'b1;
            end
            prox_pkg::B_ADDR: begin
               if (scl_rise) begin
                  shift_next = {shift_reg[6:0], sda_sync};
                  cnt_next = cnt_reg + 4'h1;
               end else if (scl_fall && cnt_reg == 4'h8) begin
                  if (shift_reg[7:1] == prox_pkg::SLAVE_ADDR) begin
                     bus_next = prox_pkg::B_ACK_ADDR;
                     rw_next = shift_reg[0];
                     oe_b_next = 1'b0;
                  end else begin
                     bus_next = prox_pkg::B_IDLE;
                  end
               end
            end
            prox_pkg::B_ACK_ADDR: begin
               if (scl_fall) begin
                  cnt_next = 4'h0;
                  if (rw_reg) begin
                     // (RULE20) read uses stored address
                     do_load = 1'b1;
                     bus_next = prox_pkg::B_TX;
                  end else begin
                     oe_b_next = 1'b1;
                     bus_next = prox_pkg::B_RX;
                  end
               end
            end
            prox_pkg::B_RX: begin
               if (scl_rise) begin
                  shift_next = {shift_reg[6:0], sda_sync};
                  cnt_next = cnt_reg + 4'h1;
               end else if (scl_fall && cnt_reg == 4'h8) begin
                  do_write = 1'b1;
                  first_next = 1'b0;
                  oe_b_next = 1'b0;
                  bus_next = prox_pkg::B_ACK_RX;
               end
            end
            prox_pkg::B_ACK_RX: begin
               if (scl_fall) begin
                  cnt_next = 4'h0;
                  oe_b_next = 1'b1;
                  bus_next = prox_pkg::B_RX;
               end
            end
            prox_pkg::B_TX: begin
               if (scl_fall) begin
                  if (cnt_reg == 4'h7) begin
                     oe_b_next = 1'b1;
                     bus_next = prox_pkg::B_ACK_TX;
                  end else begin
                     tx_next = {tx_reg[6:0], 1'b0};
                     oe_b_next = tx_next[7];
                     cnt_next = cnt_reg + 4'h1;
                  end
               end
            end
            prox_pkg::B_ACK_TX: begin
               if (scl_rise) begin
                  nack_next = sda_sync;
               end else if (scl_fall) begin
                  cnt_next = 4'h0;
                  if (nack_reg) begin
                     bus_next = prox_pkg::B_IDLE;
                  end else begin
                     do_load = 1'b1;
                     bus_next = prox_pkg::B_TX;
                  end
               end
            end
            default: begin
               bus_next = prox_pkg::B_IDLE;
               oe_b_next = 1'b1;
            end
         endcase
      end
      if (do_load) begin
         tx_next = read_byte(regs_reg, regs_reg.cmd.addr, pend_reg, result_reg, shadow_reg);
         oe_b_next = tx_next[7];
         // upper byte held so a two-byte read stays coherent
         if (regs_reg.cmd.addr == prox_pkg::ADDR_DATA_L) begin
            shadow_next = result_reg[15:8];
         end
         // (RULE4) auto-increment after read
         if (regs_reg.cmd.kind == prox_pkg::CMD_AUTO) begin
            regs_next.cmd.addr = regs_reg.cmd.addr + 5'h01;
         end
      end
      // (RULE1) (RULE25) first top-bit byte is command
      if (do_write && first_reg && shift_reg[prox_pkg::CMD_SEL_BIT]) begin
         // (RULE2) (RULE5) decode type and field
         if (shift_reg[6:5] == prox_pkg::CMD_SPECIAL) begin
            // (RULE6) one-cycle interrupt clear
            clear_req = (shift_reg[4:0] == prox_pkg::SF_CLEAR);
         end else begin
            regs_next.cmd = shift_reg[6:0];
         end
      end else if (do_write) begin
         case (regs_reg.cmd.addr)
            prox_pkg::ADDR_ENABLE: regs_next.enable = shift_reg;
            prox_pkg::ADDR_ITIME: regs_next.itime = shift_reg;
            prox_pkg::ADDR_WAIT: regs_next.wait_steps = shift_reg;
            // (RULE18) threshold byte assembly
            prox_pkg::ADDR_LO_L: regs_next.lo_thr[7:0] = shift_reg;
            prox_pkg::ADDR_LO_H: regs_next.lo_thr[15:8] = shift_reg;
            prox_pkg::ADDR_HI_L: regs_next.hi_thr[7:0] = shift_reg;
            prox_pkg::ADDR_HI_H: regs_next.hi_thr[15:8] = shift_reg;
            prox_pkg::ADDR_PERS: regs_next.pers = shift_reg;
            prox_pkg::ADDR_CONFIG: regs_next.config_b = shift_reg;
            default: regs_next.enable = regs_reg.enable;
         endcase
         // (RULE3) (RULE4) repeated holds, auto advances
         if (regs_reg.cmd.kind == prox_pkg::CMD_AUTO) begin
            regs_next.cmd.addr = regs_reg.cmd.addr + 5'h01;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bus_reg <= prox_pkg::B_IDLE;
         regs_reg <= '{enable: prox_pkg::ENABLE_RST, itime: prox_pkg::ITIME_RST,
                       wait_steps: prox_pkg::WAIT_RST, pers: prox_pkg::PERS_RST,
                       config_b: prox_pkg::CONFIG_RST, lo_thr: prox_pkg::THR_RST,
                       hi_thr: prox_pkg::THR_RST, cmd: prox_pkg::CMD_RST};
         cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         tx_reg <= 8'h00;
         shadow_reg <= 8'h00;
         rw_reg <= 1'b0;
         first_reg <= 1'b0;
         nack_reg <= 1'b1;
         oe_b_reg <= 1'b1;
      end else begin
         bus_reg <= bus_next;
         regs_reg <= regs_next;
         cnt_reg <= cnt_next;
         shift_reg <= shift_next;
         tx_reg <= tx_next;
         shadow_reg <= shadow_next;
         rw_reg <= rw_next;
         first_reg <= first_next;
         nack_reg <= nack_next;
         oe_b_reg <= oe_b_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sequencer and interrupt filter

   prox_pkg::seq_state_e seq_reg, seq_next;
   logic [18:0] step_reg, step_next;
   logic [11:0] left_reg, left_next;
   logic [3:0] pers_cnt_reg, pers_cnt_next;
   logic tick;
   logic osc_on, prox_on, wait_on, irq_mask, long_wait;
   logic [3:0] pers_limit;

   assign osc_on = regs_reg.enable[prox_pkg::EN_OSC_BIT];
   assign prox_on = regs_reg.enable[prox_pkg::EN_PROX_LSB +: 2] == prox_pkg::PROX_ON;
   assign wait_on = regs_reg.enable[prox_pkg::EN_WAIT_BIT];
   assign irq_mask = regs_reg.enable[prox_pkg::EN_MASK_BIT];
   assign long_wait = regs_reg.config_b[prox_pkg::CFG_LONG_BIT];
   assign pers_limit = regs_reg.pers[prox_pkg::PERS_LSB +: 4];
   assign tick = step_reg == 19'(STEP_CYCLES - 1);

   always_comb begin
      logic done;
      logic out_range;
      logic fire;
      done = 1'b0;
      out_range = 1'b0;
      fire = 1'b0;
      seq_next = seq_reg;
      left_next = left_reg;
      result_next = result_reg;
      pers_cnt_next = pers_cnt_reg;
      step_next = tick ? 19'h00000 : step_reg + 19'h00001;
      case (seq_reg)
         prox_pkg::S_SLEEP: begin
            // (RULE11) power-on delay before start
            if (osc_on) seq_next = prox_pkg::S_START_DLY;
         end
         prox_pkg::S_START_DLY: begin
            if (tick) seq_next = prox_pkg::S_START;
         end
         prox_pkg::S_START: begin
            // (RULE9) (RULE21) proximity only when enabled
            seq_next = prox_on ? prox_pkg::S_ACCUM : prox_pkg::S_WAIT_CHECK;
         end
         prox_pkg::S_ACCUM: begin
            // (RULE14) integration length in steps
            left_next = {3'h0, steps_of(regs_reg.itime)};
            seq_next = prox_pkg::S_CONVERT;
         end
         prox_pkg::S_CONVERT: begin
            if (tick) begin
               if (left_reg == 12'h001) begin
                  done = 1'b1;
                  result_next = prox_adc_value;
                  seq_next = prox_pkg::S_WAIT_CHECK;
               end else begin
                  left_next = left_reg - 12'h001;
               end
            end
         end
         prox_pkg::S_WAIT_CHECK: begin
            // (RULE8) (RULE16) wait pass and its length
            left_next = {3'h0, steps_of(regs_reg.wait_steps)};
            if (long_wait) left_next = left_next * prox_pkg::LONG_WAIT_FACTOR;
            seq_next = wait_on ? prox_pkg::S_WAIT : prox_pkg::S_START;
         end
         prox_pkg::S_WAIT: begin
            if (tick) begin
               if (left_reg == 12'h001) begin
                  seq_next = prox_pkg::S_WAIT_DLY;
               end else begin
                  left_next = left_reg - 12'h001;
               end
            end
         end
         prox_pkg::S_WAIT_DLY: begin
            if (tick) seq_next = prox_pkg::S_START;
         end
         default: seq_next = prox_pkg::S_SLEEP;
      endcase
      // (RULE10) oscillator off stops all timing
      if (!osc_on) seq_next = prox_pkg::S_SLEEP;
      if (seq_next != seq_reg || seq_reg == prox_pkg::S_SLEEP) step_next = 19'h00000;
      // (RULE19) threshold comparison
      out_range = (result_next < regs_reg.lo_thr) || (result_next > regs_reg.hi_thr);
      if (done) begin
         // (RULE22) persistence filter
         if (pers_limit == 4'h0) begin
            fire = 1'b1;
         end else if (out_range) begin
            if (pers_cnt_reg != 4'hF) pers_cnt_next = pers_cnt_reg + 4'h1;
            fire = pers_cnt_next >= pers_limit;
         end else begin
            pers_cnt_next = 4'h0;
         end
      end
      // (RULE7) mask gates generation; set beats clear
      if (fire && irq_mask) pend_next = 1'b1;
      else if (clear_req) pend_next = 1'b0;
      else pend_next = pend_reg;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         seq_reg <= prox_pkg::S_SLEEP;
         step_reg <= 19'h00000;
         left_reg <= 12'h000;
         pers_cnt_reg <= 4'h0;
         pend_reg <= 1'b0;
         result_reg <= 16'h0000;
      end else begin
         seq_reg <= seq_next;
         step_reg <= step_next;
         left_reg <= left_next;
         pers_cnt_reg <= pers_cnt_next;
         pend_reg <= pend_next;
         result_reg <= result_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pins

   assign sda_o = 1'b0;
   assign sda_oe_b = oe_b_reg;
   assign int_o = 1'b0;
   // (RULE24) pin pulled low while pending and unmasked
   assign int_oe_b = ~(pend_reg & irq_mask);
   assign conv_start = seq_reg == prox_pkg::S_ACCUM;

endmodule // prox_control

// [bench/prox_control_chk.sv]
/* Pin checks for prox_control.
 Assumes a bind into prox_control, one clock domain. */
`timescale 1ns/100ps
module prox_control_chk #(
   parameter int STEP_CYCLES = 20
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_o,
   input wire logic sda_oe_b,
   input wire logic int_o,
   input wire logic int_oe_b,
   input wire logic conv_start,
   input wire logic [15:0] prox_adc_value
);
   int gap_reg;
   int gap_next;
   // cycles since the last conversion start, saturating
   always_comb begin
      gap_next = conv_start ? 0 : gap_reg + ((gap_reg < 100000) ? 1 : 0);
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         gap_reg <= 0;
      end else begin
         gap_reg <= gap_next;
      end
   end
   //////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   sda_level_a: assert property (sda_o == 1'b0)
      else $error("data value not low");
   irq_level_a: assert property (int_o == 1'b0)
      else $error("interrupt value not low");
   ack_edge_a: assert property ($fell(sda_oe_b) |-> !scl_in)
      else $error("data pulled while clock high");
   ack_hold_a: assert property ($fell(sda_oe_b) |-> !sda_oe_b [*8])
      else $error("data pull too short");
   conv_pulse_a: assert property (conv_start |=> !conv_start)
      else $error("conversion start too long");
   conv_gap_a: assert property (conv_start |-> gap_reg >= STEP_CYCLES)
      else $error("conversions closer than one step");
   irq_clear_a: assert property ($rose(int_oe_b) |-> !scl_in)
      else $error("interrupt released mid bit");
   irq_set_a: assert property ($fell(int_oe_b) |-> gap_reg >= STEP_CYCLES)
      else $error("interrupt without finished conversion");
   cover property (conv_start);
   cover property ($fell(int_oe_b));
   cover property ($rose(int_oe_b));
endmodule // prox_control_chk

// [bench/i2c_host_model.sv]
/* Two-wire bus host model standing in for the processor.
 Assumes the bench resolves the data wire with a pull-up. */
`timescale 1ns/100ps
module i2c_host_model (
   input wire logic clk,
   input wire logic sda_in,
   output logic scl_o,
   output logic sda_pull
);
   initial begin
      scl_o = 1'b1;
      sda_pull = 1'b0;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge clk);
   endtask
   // one bit: data set while clock low, sampled at end of high phase
   task automatic bit_io(input logic b, output logic r);
      sda_pull <= !b;
      hold(10);
      scl_o <= 1'b1;
      hold(10);
      r = sda_in;
      scl_o <= 1'b0;
      hold(1);
   endtask
   task automatic start();
      sda_pull <= 1'b0;
      hold(10);
      scl_o <= 1'b1;
      hold(10);
      sda_pull <= 1'b1;
      hold(10);
      scl_o <= 1'b0;
      hold(10);
   endtask
   task automatic stop();
      sda_pull <= 1'b1;
      hold(10);
      scl_o <= 1'b1;
      hold(10);
      sda_pull <= 1'b0;
      hold(10);
   endtask
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], r);
      end
      bit_io(1'b1, r);
      ack = !r;
   endtask
   task automatic rbyte(input logic nack, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, b[i]);
      end
      bit_io(nack, r);
   endtask
endmodule // i2c_host_model

// [bench/prox_control_tb.sv]
/* Bench for prox_control: registers, command types, interrupt, timing.
 Assumes the host model owns the bus; adc input is set here. */
`timescale 1ns/100ps
module prox_control_tb;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
      logic [7:0] exp_b;
   } row_s;
   localparam int STEP = 20;
   localparam logic [7:0] WR = {prox_pkg::SLAVE_ADDR, 1'b0};
   localparam logic [7:0] RD = {prox_pkg::SLAVE_ADDR, 1'b1};
   logic clk, rst_b, scl, host_pull, sda_o, sda_oe_b, int_o, int_oe_b, conv_start, sda_wire;
   logic [15:0] adc;
   logic [31:0] d;
   int failures, num_checks, p0, p1;
   row_s rows [8];
   assign sda_wire = (host_pull || (!sda_oe_b && !sda_o)) ? 1'b0 : 1'b1;
   prox_control #(.STEP_CYCLES(STEP)) dut (.clk(clk), .rst_b(rst_b), .scl_in(scl),
      .sda_in(sda_wire), .sda_o(sda_o), .sda_oe_b(sda_oe_b), .int_o(int_o),
      .int_oe_b(int_oe_b), .conv_start(conv_start), .prox_adc_value(adc));
   i2c_host_model host (.clk(clk), .sda_in(sda_wire), .scl_o(scl), .sda_pull(host_pull));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   //////////////////////////////////////////////////
   task automatic give_verdict();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_range(input int got, input int lo, input int hi);
      num_checks++;
      if (got < lo || got > hi) begin
         failures++;
         $display("mismatch at %0t: count %0d", $time, got);
      end
   endtask
   task automatic expire();
      failures++;
      $display("mismatch at %0t: wait ran out", $time);
      give_verdict();
   endtask
   task automatic wr_reg(input logic [7:0] cmd, input logic [31:0] v, input int n);
      logic ack;
      host.start();
      host.wbyte(WR, ack);
      host.wbyte(cmd, ack);
      for (int i = 0; i < n; i++) begin
         host.wbyte(v[8*i +: 8], ack);
      end
      check_val({31'h0, ack}, 32'h1);
      host.stop();
   endtask
   task automatic rd_reg(input logic [7:0] cmd, input logic use_cmd, input int n);
      logic ack;
      d = 32'h0;
      host.start();
      if (use_cmd) begin
         host.wbyte(WR, ack);
         host.wbyte(cmd, ack);
         host.start();
      end
      host.wbyte(RD, ack);
      for (int i = 0; i < n; i++) begin
         host.rbyte(i == n - 1, d[8*i +: 8]);
      end
      host.stop();
   endtask
   task automatic wait_pin(input logic lvl);
      int k;
      k = 0;
      while (int_oe_b !== lvl && k < 1000) begin
         @(negedge clk);
         k++;
      end
      if (int_oe_b !== lvl) begin
         expire();
      end
      @(posedge clk);
   endtask
   task automatic period(output int p);
      int k;
      k = 0;
      p = 0;
      @(negedge clk);
      while (conv_start !== 1'b1 && k < 2000) begin
         @(negedge clk);
         k++;
      end
      @(negedge clk);
      while (conv_start !== 1'b1 && p < 2000) begin
         @(negedge clk);
         p++;
      end
      if (p >= 2000 || k >= 2000) begin
         expire();
      end
      @(posedge clk);
   endtask
   //////////////////////////////////////////////////
   initial begin
      failures = 0;
      num_checks = 0;
      rst_b = 1'b0;
      adc = 16'h0200;
      rows = '{'{8'h02, 8'hFF, 8'hFF}, '{8'h03, 8'hB6, 8'hB6}, '{8'h08, 8'h34, 8'h34},
         '{8'h09, 8'h12, 8'h12}, '{8'h0A, 8'h78, 8'h78}, '{8'h0B, 8'h56, 8'h56},
         '{8'h13, 8'hFF, 8'h00}, '{8'h05, 8'hAA, 8'h00}};
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      foreach (rows[i]) begin
         wr_reg(8'h80 | rows[i].addr, {24'h0, rows[i].data}, 1);
         rd_reg(8'h80 | rows[i].addr, 1'b1, 1);
         check_val(d, {24'h0, rows[i].exp_b});
      end
      $display("register table done");
      rst_b <= 1'b0;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      rd_reg(8'hA0, 1'b1, 4);
      check_val(d, 32'hFFFF_0000);
      wr_reg(8'h83, 32'h0000_FE11, 2);
      rd_reg(8'h00, 1'b0, 2);
      check_val(d, 32'h0000_FEFE);
      wr_reg(8'hA8, 32'h0300_0100, 4);
      wr_reg(8'h8C, 32'h10, 1);
      rd_reg(8'hA8, 1'b1, 4);
      check_val(d, 32'h0300_0100);
      $display("command types done");
      adc <= 16'h0400;
      wr_reg(8'h80, 32'h07, 1);
      repeat (200) @(posedge clk);
      check_val({31'h0, int_oe_b}, 32'h1);
      adc <= 16'h0200;
      wr_reg(8'h80, 32'h27, 1);
      repeat (200) @(posedge clk);
      check_val({31'h0, int_oe_b}, 32'h1);
      adc <= 16'h0050;
      wait_pin(1'b0);
      rd_reg(8'h93, 1'b1, 1);
      check_val(d, 32'h20);
      wr_reg(8'h80, 32'h21, 1);
      check_val({31'h0, int_oe_b}, 32'h0);
      wr_reg(8'hE5, 32'h0, 0);
      check_val({31'h0, int_oe_b}, 32'h1);
      wr_reg(8'hE0, 32'h0, 0);
      rd_reg(8'h00, 1'b0, 1);
      check_val(d, 32'h21);
      adc <= 16'h0400;
      wr_reg(8'h80, 32'h27, 1);
      wait_pin(1'b0);
      wr_reg(8'h80, 32'h21, 1);
      wr_reg(8'hE5, 32'h0, 0);
      check_val({31'h0, int_oe_b}, 32'h1);
      adc <= 16'h0200;
      wr_reg(8'h8C, 32'h00, 1);
      wr_reg(8'h80, 32'h27, 1);
      wait_pin(1'b0);
      wr_reg(8'h80, 32'h21, 1);
      wr_reg(8'hE5, 32'h0, 0);
      check_val({31'h0, int_oe_b}, 32'h1);
      $display("interrupt done");
      wr_reg(8'h80, 32'h07, 1);
      period(p0);
      wr_reg(8'h80, 32'h0F, 1);
      period(p1);
      check_range(p1 - p0, 3 * STEP - 1, 3 * STEP + 3);
      wr_reg(8'h8D, 32'h02, 1);
      period(p1);
      check_range(p1 - p0, 25 * STEP - 1, 25 * STEP + 3);
      wr_reg(8'h82, 32'hFE, 1);
      period(p1);
      check_range(p1 - p0, 26 * STEP - 1, 26 * STEP + 3);
      $display("wait timing done");
      give_verdict();
   end
endmodule // prox_control_tb
bind prox_control prox_control_chk #(.STEP_CYCLES(STEP_CYCLES)) chk (.clk(clk),
   .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in), .sda_o(sda_o), .sda_oe_b(sda_oe_b),
   .int_o(int_o), .int_oe_b(int_oe_b), .conv_start(conv_start),
   .prox_adc_value(prox_adc_value));
